/* File: verilog/pwm_pkg.sv */
// Constants, register map and types of the high pulse width meter
package pwm_pkg;

  localparam int          CNT_W       = 16;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TALLY_MAX   = 16'hFFFF;
  localparam int          TICK_NS     = 160;
  localparam int          CLK_NS      = 5;
  localparam int          TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          WIDTH_W     = 32;
  localparam int          NS_W        = 40;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_COUNT    = 8'h08;
  localparam logic [7:0] OFS_CAPA     = 8'h0C;
  localparam logic [7:0] OFS_TALLY    = 8'h10;
  localparam logic [7:0] OFS_WIDTH    = 8'h14;
  localparam logic [7:0] OFS_NS_LO    = 8'h18;
  localparam logic [7:0] OFS_NS_HI    = 8'h1C;
  localparam logic [7:0] OFS_INT_STAT = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;

  localparam int CTRL_START = 0;
  localparam int CTRL_HOLD  = 1;

  localparam int INT_W     = 3;
  localparam int INT_DONE  = 0;
  localparam int INT_FAULT = 1;
  localparam int INT_WRAP  = 2;
  localparam logic [2:0] INT_RST = 3'h0;

  typedef enum logic [1:0] {SVC_NONE, SVC_WRAP, SVC_CAP} pwm_svc_t;

  typedef struct packed {
    logic hold;
    logic start;
  } pwm_ctrl_t;

  typedef struct packed {
    logic wrap;
    logic cap;
  } pwm_pend_t;

  localparam pwm_ctrl_t CTRL_RST = '{hold: 1'b0, start: 1'b0};
  localparam pwm_pend_t PEND_RST = '{wrap: 1'b0, cap: 1'b0};

endpackage

/* File: verilog/pwm_meter.sv */
// High pulse width meter: capture timer, request servicing and register port
`timescale 1ns/1ps

module pwm_meter
  import pwm_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RSTN_I,
  input  wire logic              CE_I,
  input  wire logic              CAPTURE_INPUT_PIN_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [DATA_W-1:0] RDATA_O,
  output logic                   IRQ_O,
  output logic                   FAULT_O,
  output logic                   MEASURING_O
);

  localparam int PRE_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_DIV - 1);

  function automatic logic [NS_W-1:0] ticks_to_ns(input logic [WIDTH_W-1:0] ticks);
    return NS_W'(ticks) * NS_W'(TICK_NS);
  endfunction

  // Synchroniser and edge history
  logic             pin_meta;
  logic             pin_sync;
  logic             pin_prev;

  // Timer state
  logic [PRE_W-1:0] pre;
  logic [CNT_W-1:0] timer_count;
  logic [CNT_W-1:0] capture_register_a;
  logic             capture_pin_level;
  pwm_pend_t        pend;
  pwm_ctrl_t        ctrl;

  // Measurement state
  logic [CNT_W-1:0]   overflow_tally;
  logic               measuring;
  logic [WIDTH_W-1:0] width_ticks;
  logic [NS_W-1:0]    width_ns;
  logic [INT_W-1:0]   int_stat;
  logic [INT_W-1:0]   int_mask;

  // Combinational terms
  wire              tick;
  wire              cap_edge;
  wire              wrap_now;
  wire              tally_full;
  wire              ovf_fault;
  wire              meas_open;
  wire              meas_done;
  wire              tally_step;
  pwm_svc_t         svc;
  wire [PRE_W-1:0]  next_pre;
  wire [CNT_W-1:0]  next_count;
  pwm_pend_t        next_pend;
  wire [CNT_W-1:0]  next_tally;
  wire              next_measuring;
  wire              next_fault;
  wire [INT_W-1:0]  events;
  wire [INT_W-1:0]  w1c;
  wire [INT_W-1:0]  next_int_stat;
  wire [DATA_W-1:0] rd_mux;
  wire              wr_ctrl;
  wire              wr_mask;
  wire [WIDTH_W-1:0] width_now;

  // Prescaler gives one timer tick per 160 ns
  assign tick     = ctrl.start && (pre == PRE_LAST);
  assign next_pre = (!ctrl.start || tick) ? '0 : PRE_W'(pre + 1'b1);

  // Either edge of the synchronised pin is a capture; no count, no capture
  assign cap_edge = ctrl.start && (pin_sync ^ pin_prev);

  // Clear from a capture has priority over the wrap in the same cycle
  assign wrap_now = tick && (timer_count == COUNT_MAX) && !cap_edge;

  assign next_count = cap_edge ? '0 :
                      tick     ? CNT_W'(timer_count + 1'b1) :
                                 timer_count;

  // Wrap requests go first so the width sees the updated tally
  assign svc = ctrl.hold ? SVC_NONE :
               pend.wrap ? SVC_WRAP :
               pend.cap  ? SVC_CAP  : SVC_NONE;

  // A new request in the service cycle wins over its own clear
  assign next_pend = '{wrap: wrap_now || (pend.wrap && (svc != SVC_WRAP)),
                       cap:  cap_edge || (pend.cap && (svc != SVC_CAP))};

  assign tally_full = (overflow_tally == TALLY_MAX);
  assign tally_step = (svc == SVC_WRAP) && measuring && !tally_full;
  assign ovf_fault  = (svc == SVC_WRAP) && measuring && tally_full;

  // After a fault the meter stops; captures no longer open measurements
  assign meas_open = (svc == SVC_CAP) && !FAULT_O && capture_pin_level;
  assign meas_done = (svc == SVC_CAP) && !FAULT_O && !capture_pin_level && measuring;

  assign next_tally = meas_open  ? '0 :
                      tally_step ? CNT_W'(overflow_tally + 1'b1) :
                                   overflow_tally;

  assign next_measuring = ovf_fault ? 1'b0 :
                          meas_open ? 1'b1 :
                          meas_done ? 1'b0 : measuring;
  assign next_fault     = FAULT_O || ovf_fault;

  // Capture value taken as is; coincident wrap was never counted
  assign width_now = {overflow_tally, capture_register_a};

  // Register port decode
  assign wr_ctrl = WR_I && (ADDR_I == OFS_CTRL);
  assign wr_mask = WR_I && (ADDR_I == OFS_INT_MASK);
  assign w1c     = (WR_I && (ADDR_I == OFS_INT_STAT)) ? WDATA_I[INT_W-1:0] : '0;

  assign events[INT_DONE]  = meas_done;
  assign events[INT_FAULT] = ovf_fault;
  assign events[INT_WRAP]  = (svc == SVC_WRAP);
  assign next_int_stat     = (int_stat & ~w1c) | events;

  assign rd_mux =
    (ADDR_I == OFS_CTRL)     ? DATA_W'({ctrl.hold, ctrl.start}) :
    (ADDR_I == OFS_STATUS)   ? DATA_W'({pend.wrap, pend.cap, FAULT_O, measuring}) :
    (ADDR_I == OFS_COUNT)    ? DATA_W'(timer_count) :
    (ADDR_I == OFS_CAPA)     ? DATA_W'(capture_register_a) :
    (ADDR_I == OFS_TALLY)    ? DATA_W'(overflow_tally) :
    (ADDR_I == OFS_WIDTH)    ? DATA_W'(width_ticks) :
    (ADDR_I == OFS_NS_LO)    ? width_ns[DATA_W-1:0] :
    (ADDR_I == OFS_NS_HI)    ? DATA_W'(width_ns[NS_W-1:DATA_W]) :
    (ADDR_I == OFS_INT_STAT) ? DATA_W'(int_stat) :
    (ADDR_I == OFS_INT_MASK) ? DATA_W'(int_mask) : '0;

  // Pin synchroniser; only pin_sync and pin_prev feed logic
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else if (CE_I) begin
      pin_meta <= CAPTURE_INPUT_PIN_I;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Prescaler, timer and pending requests
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pre         <= '0;
      timer_count <= '0;
      pend        <= PEND_RST;
    end else if (CE_I) begin
      pre         <= next_pre;
      timer_count <= next_count;
      pend        <= next_pend;
    end
  end

  // Count copied on the edge itself, never waiting for service
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      capture_register_a <= '0;
      capture_pin_level  <= 1'b0;
    end else if (CE_I && cap_edge) begin
      capture_register_a <= timer_count;
      capture_pin_level  <= pin_sync;
    end
  end

  // Measurement state
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      overflow_tally <= '0;
      measuring      <= 1'b0;
      FAULT_O        <= 1'b0;
      MEASURING_O    <= 1'b0;
    end else if (CE_I) begin
      overflow_tally <= next_tally;
      measuring      <= next_measuring;
      FAULT_O        <= next_fault;
      MEASURING_O    <= next_measuring;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      width_ticks <= '0;
      width_ns    <= '0;
    end else if (CE_I && meas_done) begin
      width_ticks <= width_now;
      width_ns    <= ticks_to_ns(width_now);
    end
  end

  // Software registers, interrupt and read port
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl     <= CTRL_RST;
      int_stat <= INT_RST;
      int_mask <= INT_RST;
      IRQ_O    <= 1'b0;
      RDATA_O  <= '0;
    end else if (CE_I) begin
      if (wr_ctrl) begin
        ctrl <= '{hold: WDATA_I[CTRL_HOLD], start: WDATA_I[CTRL_START]};
      end
      if (wr_mask) begin
        int_mask <= WDATA_I[INT_W-1:0];
      end
      int_stat <= next_int_stat;
      IRQ_O    <= |(next_int_stat & (wr_mask ? WDATA_I[INT_W-1:0] : int_mask));
      RDATA_O  <= RD_I ? rd_mux : '0;
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence s_edge_at_max;
    CE_I && cap_edge && (timer_count == COUNT_MAX);
  endsequence

  sequence s_last_overflow;
    CE_I && (svc == SVC_WRAP) && measuring && tally_full;
  endsequence

  sequence s_close_meas;
    CE_I && (svc == SVC_CAP) && !FAULT_O && !capture_pin_level && measuring;
  endsequence

  sequence s_close_at_max;
    s_close_meas ##0 (capture_register_a == COUNT_MAX);
  endsequence

  a_capture_at_max: assert property (
    s_edge_at_max |=> (capture_register_a == COUNT_MAX) && (timer_count == '0) && pend.cap)
    else $error("edge at top count did not capture top value and clear");

  a_clear_beats_wrap: assert property (
    s_edge_at_max ##0 (tick && !pend.wrap) |=> !pend.wrap)
    else $error("wrap request raised together with capture clear");

  a_wrap_sets_pend: assert property (
    CE_I && tick && (timer_count == COUNT_MAX) && !cap_edge |=> pend.wrap && (timer_count == '0))
    else $error("counter wrap did not raise wrap request");

  a_hold_keeps_pend: assert property (
    CE_I && ctrl.hold && pend.wrap |=> pend.wrap)
    else $error("pending wrap lost during hold");

  a_capture_copies: assert property (
    CE_I && cap_edge |=> (capture_register_a == $past(timer_count)) && pend.cap)
    else $error("capture did not copy count");

  a_wrap_first: assert property (
    CE_I && !ctrl.hold && pend.wrap && pend.cap |=> pend.cap)
    else $error("capture serviced ahead of wrap");

  a_tally_step: assert property (
    CE_I && tally_step |=> overflow_tally == $past(overflow_tally) + 16'h0001)
    else $error("tally did not advance by one");

  a_tally_idle: assert property (
    CE_I && (svc == SVC_WRAP) && !measuring |=> $stable(overflow_tally))
    else $error("tally changed outside measurement");

  a_open_meas: assert property (
    CE_I && meas_open |=> measuring && MEASURING_O && (overflow_tally == '0))
    else $error("measurement not opened on high level");

  a_width_calc: assert property (
    s_close_meas |=> (width_ticks == {$past(overflow_tally), $past(capture_register_a)})
                     && !measuring ##0 (width_ns == NS_W'(width_ticks) * NS_W'(TICK_NS)))
    else $error("width not computed from tally and capture");

  a_fault_stop: assert property (
    s_last_overflow |=> FAULT_O && !measuring ##1 FAULT_O)
    else $error("tally overflow did not raise fault and stop");

  a_fault_sticky: assert property (
    FAULT_O |=> FAULT_O)
    else $error("fault flag dropped");

  a_idle_count: assert property (
    CE_I && !ctrl.start |=> $stable(timer_count) && !$rose(pend.cap))
    else $error("timer moved before start");

  a_low_part_kept: assert property (
    s_close_at_max |=> (width_ticks[CNT_W-1:0] == COUNT_MAX)
                       && (width_ticks[WIDTH_W-1:CNT_W] == $past(overflow_tally)))
    else $error("top capture value not used unchanged in width");

  a_edge_clears: assert property (
    CE_I && cap_edge |=> (timer_count == '0))
    else $error("capture edge did not clear the count");

  a_pin_coding: assert property (
    CE_I && cap_edge |=> (capture_pin_level == $past(pin_sync)))
    else $error("captured pin level not taken from the edge");

  a_close_flag: assert property (
    CE_I && meas_done |=> !measuring && !MEASURING_O)
    else $error("measuring flag still set after closing edge");

  a_irq_level: assert property (
    CE_I |=> (IRQ_O == |(int_stat & int_mask)))
    else $error("interrupt line does not follow masked status");

  a_set_wins: assert property (
    CE_I && (|events) |=> ((int_stat & $past(events)) == $past(events)))
    else $error("status event lost to a clear in the same cycle");

  a_read_idle: assert property (
    CE_I && !RD_I |=> (RDATA_O == '0))
    else $error("read data not zero outside the read cycle");

endmodule

/* File: verif/pwm_pulse_src.sv */
// External pulse source model driving the capture input of the meter
`timescale 1ns/1ps
module pwm_pulse_src (
  input  wire logic clk_i,
  output logic      pin_o
);
  // A real source idles low between pulses
  initial pin_o = 1'b0;

  // Holds one level for n clocks, changing just after a rising edge
  task automatic drive(input logic lvl, input int n);
    @(posedge clk_i);
    pin_o <= lvl;
    repeat (n - 1) @(posedge clk_i);
  endtask
endmodule

/* File: verif/pwm_meter_tb_top.sv */
// Self-checking testbench of the high pulse width meter
`timescale 1ns/1ps
module pwm_meter_tb_top import pwm_pkg::*;;
  typedef struct {
    int                hi;
    logic [DATA_W-1:0] tally;
    logic [DATA_W-1:0] width;
  } pwm_row_t;

  logic              clk;
  logic              rst_n;
  logic              ce;
  logic              pin;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              fault;
  logic              meas;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] capa;
  int                err_count;
  int                n_checks;
  // A pulse of n ticks reads n-1: the clearing tick itself is not counted
  pwm_row_t          rows [4] = '{'{20, 0, 32'h13}, '{50, 0, 32'h31},
                                  '{257, 0, 32'h100}, '{1000, 0, 32'h3E7}};
  // High for 65802 ticks across one wrap that the stall holds back
  localparam logic [DATA_W-1:0] STALL_W = 32'h00010109;

  // One tick per clock keeps a counter wrap within the run length
  pwm_meter #(.TICK_DIV(1)) u_dut (
    .CORE_CLK_I          (clk),
    .RSTN_I              (rst_n),
    .CE_I                (ce),
    .CAPTURE_INPUT_PIN_I (pin),
    .ADDR_I              (addr),
    .WDATA_I             (wdata),
    .WR_I                (wr),
    .RD_I                (rd),
    .RDATA_O             (rdata),
    .IRQ_O               (irq),
    .FAULT_O             (fault),
    .MEASURING_O         (meas)
  );

  pwm_pulse_src u_src (
    .clk_i (clk),
    .pin_o (pin)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd_reg(a, d);
    chk(d, e);
  endtask

  task automatic results;
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The run needs about 70k clocks; this leaves a wide margin
  initial begin
    #500000;
    err_count++;
    results;
  end

  initial begin
    rst_n = 1'b0;
    ce    = 1'b1;
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({29'h0, irq, fault, meas}, 32'h0);
    u_src.drive(1'b1, 30);
    u_src.drive(1'b0, 30);
    rd_chk(OFS_CAPA, 32'h0);
    rd_chk(OFS_COUNT, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(8'h30, 32'h0);
    @(posedge clk);
    #1 chk(rdata, 32'h0);
    wr_reg(OFS_CTRL, 32'h1);
    foreach (rows[i]) begin
      u_src.drive(1'b1, rows[i].hi);
      #1 chk({31'h0, meas}, 32'h1);
      u_src.drive(1'b0, 40);
      #1 chk({31'h0, meas}, 32'h0);
      rd_reg(OFS_WIDTH, w);
      chk(w, rows[i].width);
      rd_chk(OFS_NS_LO, DATA_W'(rows[i].width * TICK_NS));
      rd_chk(OFS_TALLY, rows[i].tally);
      chk({31'h0, irq}, 32'h0);
    end
    rd_chk(OFS_NS_HI, 32'h0);
    rd_chk(OFS_INT_STAT, 32'h1);
    wr_reg(OFS_INT_STAT, 32'h7);
    rd_chk(OFS_INT_STAT, 32'h0);
    wr_reg(OFS_INT_MASK, 32'h7);
    // Stall servicing across a wrap and the closing edge
    u_src.drive(1'b1, 65000);
    wr_reg(OFS_CTRL, 32'h3);
    u_src.drive(1'b1, 800);
    u_src.drive(1'b0, 20);
    rd_chk(OFS_STATUS, 32'hD);
    rd_chk(OFS_TALLY, 32'h0);
    rd_chk(OFS_WIDTH, rows[3].width);
    rd_reg(OFS_CAPA, capa);
    chk(capa, {16'h0000, STALL_W[15:0]});
    wr_reg(OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    rd_chk(OFS_TALLY, 32'h1);
    rd_chk(OFS_WIDTH, STALL_W);
    rd_chk(OFS_STATUS, 32'h0);
    chk({30'h0, fault, irq}, 32'h1);
    rd_chk(OFS_INT_STAT, 32'h5);
    wr_reg(OFS_INT_STAT, 32'h5);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    u_src.drive(1'b1, 100);
    u_src.drive(1'b0, 40);
    rd_chk(OFS_TALLY, 32'h0);
    // Ten frozen clocks inside a window of thirteen leave three counts
    rd_reg(OFS_COUNT, capa);
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    rd_reg(OFS_COUNT, w);
    chk(w - capa, 32'h3);
    results;
  end
endmodule
